// file: verilog/adc_sequencer_result_regs.sv
/*
  Sequencer and register file of a 10-bit successive-approximation
  converter, reached over a classic Wishbone slave.
  Assumes the analog core holds a settled code on conv_data_i when the
  conversion time has run out, and that the power controller drives
  the standby levels on this same clock.
*/
// How it works
// R01: 8-bit layout shows bits 9..2 high
// R02: 10-bit layout shows bits 9..8, zeros above
// R03: Low result shows bits 7..0, read only
// R04: Single mode plus start converts once
// R05: Completion stores result, sets flag, interrupts together
// R06: Start bit clears itself after conversion begins
// R07: Software must not restart while converting
// R08: Repeat mode restarts after every completion
// R09: Writing off mode aborts, nothing stored
// R10: Result stored only after selected time
// R11: Reading high result clears end flag
// R12: New start clears flag, keeps old result
// R13: Deep standby aborts and resets control, results
// R14: No automatic resume after deep standby
// R15: Reference switch opens during deep standby
// R16: Idle-2 behaviour follows its run bit
// R17: Software configures first, then sets start
// R18: Software avoids port traffic while converting
// R19: Result is a 10-bit unsigned code
// R20: Layout bit zero is 10-bit, one 8-bit
// R21: Busy set at start, cleared at finish
// R22: Time codes select 78 to 1248 cycles
// R23: Idle-2 run bit zero stops, one runs
// R24: Channel picks one of sixteen, busy locks
// R25: Interrupt is one pulse with the flag
`default_nettype none

module adc_sequencer_result_regs
  import adc_seq_pkg::*;
(
  input  wire logic        clk_i,                 // System clock, 25 MHz
  input  wire logic        sys_rst_i,             // Async reset, high
  input  wire logic        cyc_i,                 // Wishbone cycle
  input  wire logic        stb_i,                 // Wishbone strobe
  input  wire logic        we_i,                  // Wishbone write
  input  wire logic [11:0] adr_i,                 // Byte address
  input  wire logic [3:0]  sel_i,                 // Byte enables
  input  wire logic [31:0] dat_i,                 // Write data
  output logic      [31:0] dat_o,                 // Read data
  output logic             ack_o,                 // Wishbone ack
  input  wire logic [9:0]  conv_data_i,           // Code from the core
  input  wire logic        idle_one_standby_i,    // Idle-1 entered
  input  wire logic        stop_standby_i,        // Stop entered
  input  wire logic        slow_standby_i,        // Slow entered
  input  wire logic        idle_two_standby_i,    // Idle-2 entered
  output logic             sample_start_o,        // Core start pulse
  output logic             conv_active_o,         // Core converting
  output logic      [3:0]  channel_select_o,      // Input mux select
  output logic             analog_input_enable_o, // Input path enable
  output logic             vref_connect_o,        // Reference switch
  output logic             conversion_done_irq_o  // Done interrupt
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic        ack_r;          // Bus answer
  logic [31:0] dat_r;          // Captured read data
  logic        start_r;        // Start bit, lives one cycle
  logic [1:0]  mode_r;         // Operating mode
  logic        ain_en_r;       // Analog input enable
  logic [3:0]  chan_r;         // Channel select
  logic        layout_r;       // Result layout select
  logic        idle_two_standby_run_r;    // Keep running in idle-2
  logic [3:0]  time_r;         // Conversion time code
  logic        eoc_r;          // End-of-conversion flag
  logic [9:0]  result_r;       // Last stored code
  logic        irq_r;          // Interrupt pulse
  logic        pulse_r;        // Core start pulse
  logic        active_r;       // Core converting
  logic        vref_r;         // Reference switch closed
  seq_state_e  state_r;        // Sequencer state
  seq_state_e  state_nxt;      // Its next value
  logic        tmr_done;       // Timer end pulse

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire       req_w    = cyc_i & stb_i;
  wire       take_w   = req_w & ~ack_r;      // Read data captured
  wire       fire_w   = req_w & ack_r;       // Edge the master sees ack
  wire       wr_w     = fire_w & we_i & sel_i[0];
  wire       rd_w     = fire_w & ~we_i;
  wire [9:0] word_w   = adr_i[11:2];
  wire       hit_one  = (word_w == CTRL_ONE_IDX);
  wire       hit_two  = (word_w == CTRL_TWO_IDX);
  wire       hit_low  = (word_w == RES_LOW_IDX);
  wire       hit_high = (word_w == RES_HIGH_IDX);
  wire       wr_one   = wr_w & hit_one;
  wire       wr_two   = wr_w & hit_two;
  wire       rd_high  = rd_w & hit_high;

  // ------------------------------------------------------------------
  // Power and sequencing decode
  // ------------------------------------------------------------------
  // Deep standby forces initialization
  wire stby_w   = idle_one_standby_i | stop_standby_i | slow_standby_i;
  // R16 idle-2 gate
  // R23 run bit
  wire halt_w   = stby_w | (idle_two_standby_i & ~idle_two_standby_run_r);
  wire busy_w   = (state_r == ST_CONV);
  wire mode_ok  = (mode_r == MODE_SINGLE) | (mode_r == MODE_REPEAT);
  // R04 start decode
  wire begin_w  = start_r & mode_ok & ~busy_w & ~halt_w;
  // R09 off-mode abort
  wire abort_w  = busy_w & ((mode_r == MODE_OFF) | halt_w);
  wire done_w   = busy_w & tmr_done & ~abort_w;
  // R08 repeat restart
  wire again_w  = done_w & (mode_r == MODE_REPEAT);
  wire leave_w  = abort_w | (done_w & ~again_w);  // Back to idle

  // ------------------------------------------------------------------
  // Read data selection
  // ------------------------------------------------------------------
  // R01 8-bit layout
  // R02 10-bit layout
  // R20 layout select
  wire [7:0] high_w = layout_r ? result_r[9:2] : {6'h00, result_r[9:8]};
  // R03 low result
  wire [7:0] low_w  = result_r[7:0];
  wire [7:0] one_w  = {start_r, mode_r, ain_en_r, chan_r};
  wire [7:0] two_w  = {eoc_r, busy_w, layout_r, idle_two_standby_run_r, time_r};
  // Unmapped words read as zero
  wire [7:0] rdata_w = hit_one  ? one_w  :
                       hit_two  ? two_w  :
                       hit_low  ? low_w  :
                       hit_high ? high_w : 8'h00;

  assign dat_o                 = dat_r;
  assign ack_o                 = ack_r;
  assign sample_start_o        = pulse_r;
  assign conv_active_o         = active_r;
  assign channel_select_o      = chan_r;
  assign analog_input_enable_o = ain_en_r;
  assign vref_connect_o        = vref_r;
  assign conversion_done_irq_o = irq_r;

  // ------------------------------------------------------------------
  // Wishbone answer: one wait state, ack dropped after one cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= take_w;
      dat_r <= take_w ? {24'h00_0000, rdata_w} : dat_r;
    end
  end

  // ------------------------------------------------------------------
  // Control register one
  // ------------------------------------------------------------------
  // R13 standby init
  // R24 channel locked
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_r   <= MODE_RST;
      ain_en_r <= 1'b0;
      chan_r   <= CHAN_RST;
    end else if (stby_w) begin
      mode_r   <= MODE_RST;
      ain_en_r <= 1'b0;
      chan_r   <= CHAN_RST;
    end else if (wr_one) begin
      mode_r   <= dat_i[MODE_HI:MODE_LO];
      ain_en_r <= dat_i[AIN_EN_BIT];
      chan_r   <= busy_w ? chan_r : dat_i[CHAN_HI:0];
    end
  end

  // Start bit holds for one cycle; begin_w consumes it that cycle
  // R06 self clearing
  // R14 no auto resume
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) start_r <= 1'b0;
    else start_r <= wr_one & dat_i[START_BIT] & ~stby_w;
  end

  // ------------------------------------------------------------------
  // Control register two
  // ------------------------------------------------------------------
  // R13 standby init
  // R22 time code
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      layout_r    <= 1'b0;
      idle_two_standby_run_r <= 1'b0;
      time_r      <= TIME_RST;
    end else if (stby_w) begin
      layout_r    <= 1'b0;
      idle_two_standby_run_r <= 1'b0;
      time_r      <= TIME_RST;
    end else if (wr_two) begin
      layout_r    <= dat_i[LAYOUT_BIT];
      idle_two_standby_run_r <= dat_i[IDLE_TWO_STANDBY_BIT];
      time_r      <= dat_i[TIME_HI:0];
    end
  end

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // R21 busy tracking
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = begin_w ? ST_CONV : ST_IDLE;
      ST_CONV: state_nxt = leave_w ? ST_IDLE : ST_CONV;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r  <= ST_IDLE;
      active_r <= 1'b0;
      pulse_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      active_r <= (state_nxt == ST_CONV);
      pulse_r  <= begin_w | again_w;
    end
  end

  // R10 timed completion
  conv_timer u_timer (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (begin_w | again_w),
    .abort_i   (abort_w),
    .cycles_i  (conv_cycles(time_r)),
    .done_o    (tmr_done)
  );

  // ------------------------------------------------------------------
  // Result, flag and interrupt
  // ------------------------------------------------------------------
  // R05 store on completion
  // R19 10-bit code
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_r <= RESULT_RST;
    end else if (stby_w) begin
      result_r <= RESULT_RST;
    end else if (done_w) begin
      result_r <= conv_data_i;
    end
  end

  // Set wins over a clear in the same cycle, so no completion is lost
  // R11 read clears flag
  // R12 restart clears flag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      eoc_r <= 1'b0;
    end else if (done_w) begin
      eoc_r <= 1'b1;
    end else if (stby_w || begin_w || rd_high) begin
      eoc_r <= 1'b0;
    end
  end

  // R25 single pulse
  // R15 reference switch
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_r  <= 1'b0;
      vref_r <= 1'b0;
    end else begin
      irq_r  <= done_w;
      vref_r <= ~stby_w;
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  high_eight_a: assert property ( // R01
    @(posedge clk_i) disable iff (sys_rst_i)
    take_w && hit_high && layout_r |=> dat_o[7:0] == $past(result_r[9:2]))
    else $error("high result wrong in 8-bit layout");
  high_ten_a: assert property ( // R02
    @(posedge clk_i) disable iff (sys_rst_i)
    take_w && hit_high && !layout_r
      |=> dat_o[7:2] == 6'h00 && dat_o[1:0] == $past(result_r[9:8]))
    else $error("high result wrong in 10-bit layout");
  low_result_a: assert property ( // R03
    @(posedge clk_i) disable iff (sys_rst_i)
    take_w && hit_low |=> dat_o[7:0] == $past(result_r[7:0]))
    else $error("low result wrong");
  start_busy_a: assert property ( // R21
    @(posedge clk_i) disable iff (sys_rst_i)
    begin_w |=> conv_active_o && sample_start_o && !start_r)
    else $error("start did not raise busy");
  done_store_a: assert property ( // R05
    @(posedge clk_i) disable iff (sys_rst_i)
    done_w |=> eoc_r && conversion_done_irq_o
      && result_r == $past(conv_data_i))
    else $error("completion effects missing");
  min_time_a: assert property ( // R10
    @(posedge clk_i) disable iff (sys_rst_i)
    begin_w |=> !tmr_done [*8])
    else $error("conversion ended too early");
  // A mode write may legally stop the repeat one cycle later
  repeat_on_a: assert property ( // R08
    @(posedge clk_i) disable iff (sys_rst_i)
    again_w |=> conv_active_o ##1 (conv_active_o || $past(abort_w)))
    else $error("repeat mode stopped");
  abort_keep_a: assert property ( // R09
    @(posedge clk_i) disable iff (sys_rst_i)
    abort_w && !stby_w |=> !conv_active_o && $stable(result_r)
      && !conversion_done_irq_o)
    else $error("abort stored a result");
  eoc_clear_a: assert property ( // R11
    @(posedge clk_i) disable iff (sys_rst_i)
    rd_high && !done_w |=> !eoc_r)
    else $error("high read left flag set");
  standby_init_a: assert property ( // R13
    @(posedge clk_i) disable iff (sys_rst_i)
    stby_w |=> mode_r == MODE_RST && result_r == RESULT_RST
      && time_r == TIME_RST && !vref_connect_o && !conv_active_o)
    else $error("standby did not initialize");
  irq_pulse_a: assert property ( // R25
    @(posedge clk_i) disable iff (sys_rst_i)
    conversion_done_irq_o |=> !conversion_done_irq_o)
    else $error("interrupt longer than one cycle");

endmodule : adc_sequencer_result_regs

`default_nettype wire

// file: verilog/adc_seq_pkg.sv
/*
  Constants for the converter sequencer: register word indices, field
  positions, reset values, operating modes and conversion-time counts.
  Assumes the converter clock is the system clock (25 MHz, 40 ns).
*/
`default_nettype none

package adc_seq_pkg;

  // ------------------------------------------------------------------
  // Register word indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam logic [9:0] CTRL_ONE_IDX   = 10'h2b0;
  localparam logic [9:0] CTRL_TWO_IDX   = 10'h2b1;
  localparam logic [9:0] RES_LOW_IDX    = 10'h2b2;
  localparam logic [9:0] RES_HIGH_IDX   = 10'h2b3;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int START_BIT      = 7;   // Start request, self clearing
  localparam int MODE_HI        = 6;   // Operating mode field
  localparam int MODE_LO        = 5;
  localparam int AIN_EN_BIT     = 4;   // Analog input enable
  localparam int CHAN_HI        = 3;   // Channel select field
  localparam int EOC_BIT        = 7;   // End-of-conversion flag
  localparam int BUSY_BIT       = 6;   // Busy flag
  localparam int LAYOUT_BIT     = 5;   // Result layout select
  localparam int IDLE_TWO_STANDBY_BIT      = 4;   // Keep running in idle-2
  localparam int TIME_HI        = 3;   // Conversion time field

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_RST   = 2'h0;
  localparam logic [3:0] CHAN_RST   = 4'h0;
  localparam logic [3:0] TIME_RST   = 4'hc;
  localparam logic [9:0] RESULT_RST = 10'h000;

  // ------------------------------------------------------------------
  // Operating mode codes
  // ------------------------------------------------------------------
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_REPEAT = 2'h3;

  // ------------------------------------------------------------------
  // Conversion time codes and their cycle counts
  // ------------------------------------------------------------------
  localparam logic [3:0]  TIME_78    = 4'ha;
  localparam logic [3:0]  TIME_156   = 4'hb;
  localparam logic [3:0]  TIME_312   = 4'hc;
  localparam logic [3:0]  TIME_624   = 4'hd;
  localparam logic [3:0]  TIME_1248  = 4'he;
  localparam logic [10:0] CYC_78     = 11'h04e;
  localparam logic [10:0] CYC_156    = 11'h09c;
  localparam logic [10:0] CYC_312    = 11'h138;
  localparam logic [10:0] CYC_624    = 11'h270;
  localparam logic [10:0] CYC_1248   = 11'h4e0;

  // Sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } seq_state_e;

  // Map a time code to cycles; reserved codes fall back to the longest
  function automatic logic [10:0] conv_cycles(input logic [3:0] code);
    case (code)
      TIME_78:   return CYC_78;
      TIME_156:  return CYC_156;
      TIME_312:  return CYC_312;
      TIME_624:  return CYC_624;
      default:   return CYC_1248;
    endcase
  endfunction : conv_cycles

endpackage : adc_seq_pkg

`default_nettype wire

// file: verilog/conv_timer.sv
/*
  Conversion timer: counts the selected number of clock cycles after a
  load and then gives a one-cycle done pulse.
  Assumes load and abort come from logic on the same clock.
*/
`default_nettype none

module conv_timer
  import adc_seq_pkg::*;
(
  input  wire logic        clk_i,      // System clock
  input  wire logic        sys_rst_i,  // Asynchronous reset, active high
  input  wire logic        load_i,     // Start counting a new conversion
  input  wire logic        abort_i,    // Drop the running count
  input  wire logic [10:0] cycles_i,   // Length of the conversion
  output logic             done_o      // One-cycle end pulse
);

  // ------------------------------------------------------------------
  // Count state
  // ------------------------------------------------------------------
  logic [10:0] cnt_r;      // Cycles still to run
  logic        run_r;      // Count in progress
  logic        done_r;     // Registered end pulse
  wire         zero_w = (cnt_r == 11'h000);

  assign done_o = done_r;

  // Load wins over everything, so a repeat restart never loses a cycle
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= 11'h000;
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (load_i) begin
      cnt_r  <= cycles_i - 11'h001;
      run_r  <= 1'b1;
      done_r <= 1'b0;
    end else if (abort_i) begin
      // Aborted count gives no pulse
      run_r  <= 1'b0;
      done_r <= 1'b0;
    end else if (run_r && zero_w) begin
      run_r  <= 1'b0;
      done_r <= 1'b1;
    end else begin
      cnt_r  <= run_r ? cnt_r - 11'h001 : cnt_r;
      done_r <= 1'b0;
    end
  end

endmodule : conv_timer

`default_nettype wire

// file: test/analog_core_model.sv
/*
  Behavioural analog multiplexer and converter core.
  Assumes start pulse and busy level come on the sequencer's clock.
*/
`default_nettype none

module analog_core_model (
  input  wire logic       clk_i,          // System clock
  input  wire logic       sys_rst_i,      // Async reset, high
  input  wire logic       sample_start_i, // Begin a conversion
  input  wire logic       conv_active_i,  // Sequencer busy
  input  wire logic [3:0] channel_i,      // Selected input
  output logic      [9:0] code_o          // Converted code
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [9:0] held_r; // Code of the running conversion
  logic [5:0] seq_r;  // Start count, so that codes differ

  // ------------------------------------------------------------------
  // Sampling
  // ------------------------------------------------------------------
  // ten-bit code
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held_r <= 10'h000;
      seq_r  <= 6'h00;
    end else if (sample_start_i) begin
      held_r <= {channel_i, seq_r};
      seq_r  <= seq_r + 6'h01;
    end
  end

  // Outside a conversion the code is stale: show its inverse
  assign code_o = conv_active_i ? held_r : ~held_r;

endmodule : analog_core_model

`default_nettype wire

// file: test/adc_sequencer_result_regs_tb_top.sv
/*
  Self-checking bench for the converter sequencer and result registers.
  Assumes the Wishbone timing and conversion counts of the hand-over.
*/
`default_nettype none

module adc_sequencer_result_regs_tb_top import adc_seq_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        clk_i;
  logic        sys_rst_i;
  logic        cyc_i, stb_i, we_i;
  logic [11:0] adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o;
  logic        ack_o;
  logic [9:0]  code;
  logic [2:0]  stby;      // Idle-1, stop, slow requests
  logic        idle_two_standby;     // Idle-2 request
  logic        start_p, busy, ain_en, vref, irq;
  logic [3:0]  chan;
  int          num_errors = 0;
  int          compares = 0;
  logic [5:0]  seq = 6'h00;   // Mirror of the core's start count
  logic [9:0]  last;          // Last stored result

  adc_sequencer_result_regs dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .conv_data_i(code),
    .idle_one_standby_i(stby[0]), .stop_standby_i(stby[1]),
    .slow_standby_i(stby[2]), .idle_two_standby_i(idle_two_standby),
    .sample_start_o(start_p), .conv_active_o(busy),
    .channel_select_o(chan), .analog_input_enable_o(ain_en),
    .vref_connect_o(vref), .conversion_done_irq_o(irq));

  analog_core_model core_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sample_start_i(start_p),
    .conv_active_i(busy), .channel_i(chan), .code_o(code));

  // ------------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Whole run needs about 4000 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    summarize();
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic summarize();
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [9:0] idx,
                    input logic [7:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    chk({31'h0, ack_o}, 32'h1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    wb(1'b1, idx, wd, d);
  endtask : wr

  task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    wb(1'b0, idx, 8'h00, d);
    chk(d, {24'h0, exp});
  endtask : rdc

  // quiet wait, counts edges up to lim
  task automatic wait_irq(input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clk_i);
      cnt++;
    end while (irq !== 1'b1 && cnt < lim);
  endtask : wait_irq

  task automatic start(input logic [1:0] md, input logic [3:0] ch);
    wr(CTRL_ONE_IDX, {1'b0, md, 1'b1, ch});
    wr(CTRL_ONE_IDX, {1'b1, md, 1'b1, ch});
  endtask : start

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic conv_single(input logic [3:0] t, input logic lay,
                             input logic [3:0] ch, input logic [10:0] n);
    int c;
    last = {ch, seq};
    wr(CTRL_TWO_IDX, {2'b00, lay, 1'b0, t});
    start(MODE_SINGLE, ch);
    seq++;
    // wait for completion before any restart
    wait_irq(1300, c);
    chk(32'(c), 32'(n) + 32'h3);
    @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    rdc(CTRL_TWO_IDX, {2'b10, lay, 1'b0, t});
    rdc(RES_LOW_IDX, last[7:0]);
    rdc(RES_HIGH_IDX, lay ? last[9:2] : {6'h00, last[9:8]});
    rdc(CTRL_TWO_IDX, {2'b00, lay, 1'b0, t});
  endtask : conv_single

  task automatic repeat_stop();
    int c;
    wr(CTRL_TWO_IDX, {4'h0, TIME_78});
    start(MODE_REPEAT, 4'h9);
    rdc(CTRL_ONE_IDX, {1'b0, MODE_REPEAT, 1'b1, 4'h9});
    rdc(CTRL_TWO_IDX, {4'h4, TIME_78});
    // Channel change while busy must be dropped
    wr(CTRL_ONE_IDX, {1'b0, MODE_REPEAT, 1'b1, 4'h2});
    wait_irq(200, c);
    chk({28'h0, chan}, 32'h9);
    wait_irq(200, c);
    chk(32'(c), 32'(CYC_78) + 32'h1);
    last = {4'h9, seq + 6'h01};
    seq = seq + 6'h03;
    wr(CTRL_ONE_IDX, {1'b0, MODE_OFF, 1'b1, 4'h9});
    wait_irq(200, c);
    chk(32'(c), 32'h0000_00c8);
    rdc(CTRL_TWO_IDX, {4'h8, TIME_78});
    rdc(RES_LOW_IDX, last[7:0]);
  endtask : repeat_stop

  task automatic standby(input int k);
    int c;
    wr(CTRL_TWO_IDX, {4'h0, TIME_312});
    start(MODE_SINGLE, 4'h6);
    seq++;
    rdc(CTRL_TWO_IDX, {4'h4, TIME_312});
    rdc(RES_LOW_IDX, last[7:0]);
    stby <= 3'b001 << k;
    repeat (3) @(posedge clk_i);
    chk({30'h0, vref, ain_en}, 32'h0);
    rdc(CTRL_ONE_IDX, 8'h00);
    rdc(RES_LOW_IDX, 8'h00);
    rdc(RES_HIGH_IDX, 8'h00);
    stby <= 3'b000;
    last = 10'h000;
    wait_irq(100, c);
    chk(32'(c), 32'h0000_0064);
    chk({30'h0, busy, vref}, 32'h1);
  endtask : standby

  task automatic idle_two();
    int c;
    wr(CTRL_TWO_IDX, {4'h0, TIME_78});
    start(MODE_SINGLE, 4'h4);
    seq++;
    repeat (5) @(posedge clk_i);
    idle_two_standby <= 1'b1;
    wait_irq(200, c);
    chk(32'(c), 32'h0000_00c8);
    wr(CTRL_TWO_IDX, {4'h1, TIME_78});
    last = {4'h4, seq};
    start(MODE_SINGLE, 4'h4);
    seq++;
    wait_irq(200, c);
    chk(32'(c), 32'(CYC_78) + 32'h3);
    idle_two_standby <= 1'b0;
    rdc(RES_LOW_IDX, last[7:0]);
  endtask : idle_two

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [3:0]  tc[5];
    logic [10:0] tn[5];
    tc = '{TIME_78, TIME_156, TIME_312, TIME_624, TIME_1248};
    tn = '{CYC_78, CYC_156, CYC_312, CYC_624, CYC_1248};
    sys_rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h000;
    sel_i = 4'h1;
    dat_i = 32'h0;
    stby = 3'b000;
    idle_two_standby = 1'b0;
    repeat (3) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rdc(CTRL_ONE_IDX, 8'h00);
    rdc(CTRL_TWO_IDX, {4'h0, TIME_RST});
    rdc(RES_LOW_IDX, 8'h00);
    rdc(RES_HIGH_IDX, 8'h00);
    wr(10'h100, 8'hff);
    rdc(10'h100, 8'h00);
    for (int i = 0; i < 5; i++) begin
      conv_single(tc[i], i[0], 4'(i * 3), tn[i]);
    end
    repeat_stop();
    for (int k = 0; k < 3; k++) begin
      standby(k);
    end
    idle_two();
    summarize();
  end

endmodule : adc_sequencer_result_regs_tb_top

`default_nettype wire
